// ### logic/nsap_pkg.sv
// Package for the stream access point: widths, schedule values, grid limits.
// Assumes nothing of its surroundings; every file that uses it refers to it by package::name.
package nsap_pkg;
    localparam int HORIZ_WIDTH = 288;
    localparam int VERT_WIDTH = 293;
    localparam int ID_WIDTH = 4;
    localparam int SCHED_WIDTH = 32;
    localparam logic [31:0] SCHED_DEFAULT = 32'haaaa_aaaa;
    localparam logic [31:0] SCHED_EVERY_FOURTH = 32'h8888_8888;
    localparam logic [31:0] SCHED_ILLEGAL = 32'hffff_ffff;
    localparam logic [31:0] SCHED_ILLEGAL_ALT = 32'h0fff_fffe;
    localparam int ROW_MIN = 1;
    localparam int ROW_MAX = 8;
    localparam int COL_MIN = 1;
    localparam int COL_MAX = 10;
    localparam logic RESET_OUT_LEVEL = 1'b0;
    typedef enum logic [1:0] {
        NSAP_WIN_LOCAL = 2'b01,
        NSAP_WIN_UP = 2'b10
    } nsap_win_t;
endpackage

// ### logic/nsap_arb_if.sv
// Interface carrying one arbitration point's requests and grant.
// Assumes the top module drives requests and the arbiter returns the grant.
`timescale 1ns/1ps
`default_nettype none
interface nsap_arb_if;
    logic local_req;
    logic up_req;
    logic out_ready;
    logic local_grant;
    logic up_grant;
    modport owner (output local_req, output up_req, output out_ready,
                   input local_grant, input up_grant);
    modport arb (input local_req, input up_req, input out_ready,
                 output local_grant, output up_grant);
endinterface
`default_nettype wire

// ### logic/nsap_sched_arb.sv
// Rotating-schedule arbiter between local and upstream traffic.
// Assumes requests are from logic on clk; grants are combinational.
`timescale 1ns/1ps
`default_nettype none
module nsap_sched_arb #(
    parameter logic [31:0] SCHEDULE = nsap_pkg::SCHED_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    nsap_arb_if.arb arb
);
    // An all-ones schedule never serves upstream; either illegal schedule falls back to the default
    localparam logic [31:0] SCHED_INIT =
        ((SCHEDULE == nsap_pkg::SCHED_ILLEGAL) || (SCHEDULE == nsap_pkg::SCHED_ILLEGAL_ALT)) ?
        nsap_pkg::SCHED_DEFAULT : SCHEDULE;
    logic [31:0] sched_r;
    logic contest;
    nsap_pkg::nsap_win_t win;

    assign contest = arb.local_req && arb.up_req;
    // Bit 0 picks the winner only when both compete
    always_comb begin
        if (contest) begin
            win = sched_r[0] ? nsap_pkg::NSAP_WIN_LOCAL : nsap_pkg::NSAP_WIN_UP;
        end else if (arb.local_req) begin
            win = nsap_pkg::NSAP_WIN_LOCAL;
        end else begin
            win = nsap_pkg::NSAP_WIN_UP;
        end
    end
    assign arb.local_grant = arb.out_ready && arb.local_req && (win == nsap_pkg::NSAP_WIN_LOCAL);
    assign arb.up_grant = arb.out_ready && arb.up_req && (win == nsap_pkg::NSAP_WIN_UP);

    // Rotate left after each contested cycle that actually moved a word
    always_ff @(posedge clk) begin
        if (rst) begin
            sched_r <= SCHED_INIT;
        end else if (contest && arb.out_ready) begin
            sched_r <= {sched_r[30:0], sched_r[31]};
        end
    end
endmodule
`default_nettype wire

// ### logic/nsap_top.sv
// Stream access point between user logic and one network lane pair.
// Assumes network-side ports are driven by logic on clk with valid/ready.
`timescale 1ns/1ps
`default_nettype none
module nsap_top #(
    parameter bit VERTICAL = 1'b0,
    parameter int DATA_WIDTH = VERTICAL ? nsap_pkg::VERT_WIDTH : nsap_pkg::HORIZ_WIDTH,
    parameter logic [3:0] ROW = 4'h1,
    parameter logic [3:0] COLUMN = 4'h1,
    // Fwd pattern: southbound or eastbound; rev: northbound or westbound
    parameter logic [31:0] FWD_PRIORITY_PATTERN = nsap_pkg::SCHED_DEFAULT,
    parameter logic [31:0] REV_PRIORITY_PATTERN = nsap_pkg::SCHED_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    output logic output_rst_n,
    // User transmit port
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [3:0] tx_dest,
    input wire logic tx_sop,
    input wire logic tx_eop,
    input wire logic [DATA_WIDTH-1:0] tx_data,
    // User receive port
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [3:0] rx_src,
    output logic rx_sop,
    output logic rx_eop,
    output logic [DATA_WIDTH-1:0] rx_data,
    // Upstream lanes in (index 0 forward travel, 1 reverse travel)
    input wire logic [1:0] up_valid,
    output logic [1:0] up_ready,
    input wire logic [1:0][DATA_WIDTH+9:0] up_word,
    // Downstream lanes out
    output logic [1:0] dn_valid,
    input wire logic [1:0] dn_ready,
    output logic [1:0][DATA_WIDTH+9:0] dn_word
);
    // Lane word: {dest, src, sop, eop, data}
    localparam int WW = DATA_WIDTH + 10;
    localparam int DATA_MSB = DATA_WIDTH - 1;

    // Refuse placements and widths the logic cannot serve
    initial begin
        if (ROW < nsap_pkg::ROW_MIN || ROW > nsap_pkg::ROW_MAX) begin
            $error("row out of range");
        end
        if (COLUMN < nsap_pkg::COL_MIN || COLUMN > nsap_pkg::COL_MAX) begin
            $error("column out of range");
        end
        if (DATA_WIDTH != (VERTICAL ? nsap_pkg::VERT_WIDTH : nsap_pkg::HORIZ_WIDTH)) begin
            $error("data width does not match variant");
        end
    end

    // Reserved reset output, tied low
    assign output_rst_n = nsap_pkg::RESET_OUT_LEVEL;

    logic [3:0] my_pos;
    assign my_pos = VERTICAL ? ROW : COLUMN;

    // How a word moves through this access point
    // A lane word is the user data with a small header on top:
    // the destination position, the source position and the two
    // packet flags. The header is written once, on the way in; the
    // destination is read at every hop and the rest once, on the way out,
    // so the flags ride along untouched and no logic here ever looks at them.
    //
    // There are two lanes. Lane 0 carries words toward higher positions,
    // lane 1 carries words toward lower ones or back to this position.
    // Each lane has exactly one output register. That register is the
    // only storage between the upstream neighbour and the downstream
    // neighbour, so a lane stalls as soon as its downstream side stops
    // taking words. Latency stays one cycle per hop, and in exchange a
    // stalled lane is felt upstream at once.
    //
    // A word from upstream either passes on along its lane or, when its
    // destination matches this position, is ejected into the receive
    // stage. Ejection never goes through the arbiter, because an ejected
    // word does not use the lane's output register.
    //
    // Local words from the user and passing upstream words share the
    // output register of a lane. When both want it in the same cycle,
    // the lane's schedule decides, and only then does it rotate. A
    // cycle in which the lane is blocked downstream does not rotate
    // it, so a long stall cannot skip a turn for either side.
    //
    // The receive stage is also one word deep. When both lanes hold a
    // word for this position, lane 0 goes first and lane 1 waits at least one
    // cycle; neither word is lost, since upstream holds it until ready.
    //
    // Limitations a user must know
    // The transmit ready depends on the transmit valid and destination
    // in the same cycle, so user logic must not derive its valid from
    // the ready it sees, or a combinational loop forms.
    // The reset clears only the output and receive registers of this
    // access point; words in flight between neighbours belong to the
    // network and are not touched.
    // The reserved reset output is a constant; nothing here drives it
    // from state.
    //
    // Reset timing
    // All registers reset on the clock edge at which rst is high. The
    // schedules reload their pattern at that same edge, and the first
    // word may be offered in the cycle after rst falls.

    // Per-lane output stage, one word deep; reset clears it along with the receive stage
    logic [1:0] out_v_r;
    logic [1:0][WW-1:0] out_w_r;
    logic [1:0] lane_free;
    logic [1:0] lgrant;
    logic [1:0] ugrant;
    logic tx_lane;
    logic [1:0] local_req;
    logic [1:0] up_to_me;
    logic [1:0] up_pass;
    logic rx_v_r;
    logic [WW-1:0] rx_w_r;
    logic rx_free;
    logic [1:0] eject;
    logic [WW-1:0] tx_word;

    // Destinations above our position travel forward, the rest travel back
    assign tx_lane = (tx_dest > my_pos) ? 1'b0 : 1'b1;
    assign tx_word = {tx_dest, my_pos, tx_sop, tx_eop, tx_data};
    assign rx_free = !rx_v_r || rx_ready;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            localparam logic [31:0] PAT = (g == 0) ? FWD_PRIORITY_PATTERN : REV_PRIORITY_PATTERN;
            nsap_arb_if arb_bus ();
            assign lane_free[g] = !out_v_r[g] || dn_ready[g];
            assign local_req[g] = tx_valid && (tx_lane == 1'(g));
            assign up_to_me[g] = up_word[g][WW-1 -: 4] == my_pos;
            assign up_pass[g] = up_valid[g] && !up_to_me[g];
            // Words for us leave the lane into the receive stage
            // Lane 1 yields to a lane 0 word for us, read from inputs to avoid a loop
            assign eject[g] = up_valid[g] && up_to_me[g] && rx_free
                              && !(g == 1 && up_valid[0] && up_to_me[0]);
            assign arb_bus.local_req = local_req[g];
            assign arb_bus.up_req = up_pass[g];
            assign arb_bus.out_ready = lane_free[g];
            assign lgrant[g] = arb_bus.local_grant;
            assign ugrant[g] = arb_bus.up_grant;
            assign up_ready[g] = ugrant[g] || eject[g];
            assign dn_valid[g] = out_v_r[g];
            assign dn_word[g] = out_w_r[g];

            // One schedule per direction of travel
            nsap_sched_arb #(.SCHEDULE(PAT)) u_arb (
                .clk(clk),
                .rst(rst),
                .arb(arb_bus.arb)
            );

            // Output register loads on a granted handshake only
            always_ff @(posedge clk) begin
                if (rst) begin
                    out_v_r[g] <= 1'b0;
                    out_w_r[g] <= '0;
                end else if (lgrant[g]) begin
                    out_v_r[g] <= 1'b1;
                    out_w_r[g] <= tx_word;
                end else if (ugrant[g]) begin
                    out_v_r[g] <= 1'b1;
                    out_w_r[g] <= up_word[g];
                end else if (dn_ready[g]) begin
                    out_v_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign tx_ready = |lgrant;

    // Receive stage: holds a word until user takes it
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_v_r <= 1'b0;
            rx_w_r <= '0;
        end else if (|eject) begin
            rx_v_r <= 1'b1;
            rx_w_r <= eject[0] ? up_word[0] : up_word[1];
        end else if (rx_ready) begin
            rx_v_r <= 1'b0;
        end
    end

    assign rx_valid = rx_v_r;
    assign rx_src = rx_w_r[WW-5 -: 4];
    assign rx_sop = rx_w_r[DATA_WIDTH+1];
    assign rx_eop = rx_w_r[DATA_WIDTH];
    assign rx_data = rx_w_r[DATA_MSB:0];
endmodule
`default_nettype wire

// ### sim/nsap_chk_asserts.sv
// Checker on the access point's top ports.
// Assumes lane 0 is forward travel and the position is the column.
`timescale 1ns/1ps
`default_nettype none
module nsap_chk #(parameter int W = 288, parameter logic [3:0] C = 4'h1) (
    input wire logic clk,
    input wire logic rst,
    input wire logic output_rst_n,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic [3:0] tx_dest,
    input wire logic tx_sop,
    input wire logic tx_eop,
    input wire logic [W-1:0] tx_data,
    input wire logic rx_ready,
    input wire logic rx_valid,
    input wire logic [3:0] rx_src,
    input wire logic [W-1:0] rx_data,
    input wire logic [1:0] up_valid,
    input wire logic [1:0] up_ready,
    input wire logic [1:0][W+9:0] up_word,
    input wire logic [1:0] dn_valid,
    input wire logic [1:0] dn_ready,
    input wire logic [1:0][W+9:0] dn_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted words at the ports; lane 0 upstream words addressed here eject
    wire logic tx_go = tx_valid && tx_ready;
    wire logic up_go = up_valid[0] && up_ready[0];
    wire logic [3:0] up_dst = up_word[0][W+9:W+6];
    rst_out_low_a: assert property (output_rst_n == 1'b0)
        else $error("reset out high");
    reset_clear_a: assert property ($fell(rst) |-> !rx_valid && dn_valid == 2'b00)
        else $error("valid after reset");
    fwd_word_a: assert property (tx_go && tx_dest > C |=> dn_valid[0] &&
        dn_word[0] == {$past(tx_dest), C, $past(tx_sop), $past(tx_eop), $past(tx_data)})
        else $error("forward word wrong");
    rev_word_a: assert property (tx_go && tx_dest <= C |=> dn_valid[1] &&
        dn_word[1][W+9:W+2] == {$past(tx_dest), C}) else $error("reverse word wrong");
    rx_word_a: assert property (up_go && up_dst == C |=> rx_valid &&
        {rx_src, rx_data} == $past({up_word[0][W+5:W+2], up_word[0][W-1:0]}))
        else $error("eject word wrong");
    dn_hold_a: assert property (dn_valid[0] && !dn_ready[0] |=> dn_valid[0] &&
        $stable(dn_word[0])) else $error("lane word dropped");
    rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid &&
        $stable(rx_data)) else $error("rx word dropped");
    one_grant_a: assert property (!(tx_go && tx_dest > C && up_go && up_dst != C))
        else $error("double grant");
endmodule
bind nsap_top nsap_chk #(.W(DATA_WIDTH), .C(COLUMN)) u_chk (.*);
`default_nettype wire

// ### sim/nsap_peer.sv
// Far-side user logic model: a sink whose ready stalls at random.
// Assumes it runs on the access point's clock.
`timescale 1ns/1ps
`default_nettype none
module nsap_peer #(parameter logic [7:0] SEED = 8'h5a) (
    input wire logic clk,
    input wire logic stall,
    output logic ready
);
    logic [7:0] lfsr_r = SEED;
    // Moves off the sampling edge so the design sees a settled ready
    always @(negedge clk) lfsr_r <= {lfsr_r[6:0], ^(lfsr_r & 8'hb8)};
    assign ready = !stall || lfsr_r[0];
endmodule
`default_nettype wire

// ### sim/nsap_top_test.sv
// Bench for the access point: reset, arbitration, stalled random traffic.
// Assumes the horizontal variant at column 1.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: mismatch", $time); end end
module nsap_top_test;
    localparam int W = nsap_pkg::HORIZ_WIDTH;
    int err_total = 0, samples_checked = 0;
    logic clk = 0, rst = 1, tx_valid = 0, tx_sop = 0, tx_eop = 0, stall = 0;
    logic [3:0] tx_dest = 4'h0;
    logic [W-1:0] tx_data = '0;
    logic [1:0] up_valid = 2'h0;
    logic [1:0][W+9:0] up_word = '0;
    logic [W+9:0] exp_q[3][$];
    wire logic tx_ready, rx_ready, rx_valid, rx_sop, rx_eop, output_rst_n;
    wire logic [3:0] rx_src;
    wire logic [W-1:0] rx_data;
    wire logic [1:0] up_ready, dn_valid, dn_ready;
    wire logic [1:0][W+9:0] dn_word;
    nsap_top uut (.*);
    nsap_peer #(8'h5a) peer_rx (.clk, .stall, .ready(rx_ready));
    nsap_peer #(8'h3c) peer_d0 (.clk, .stall, .ready(dn_ready[0]));
    nsap_peer #(8'hc3) peer_d1 (.clk, .stall, .ready(dn_ready[1]));
    always #5 clk = ~clk;
    // Port 2 is the user transmit side, 0 and 1 the upstream lanes
    task automatic push(input int l, input logic [3:0] d);
        logic [W+9:0] w;
        for (int k = 0; k < W; k += 32) w[k+:32] = $urandom;
        w[W+9:W] = {d, 6'($urandom)};
        if (l == 2) w[W+5:W+2] = 4'h1;
        @(negedge clk);
        if (l == 2) {tx_valid, tx_dest, tx_sop, tx_eop, tx_data} = {1'b1, d, w[W+1:0]};
        else {up_valid[l], up_word[l]} = {1'b1, w};
        #1;
        while ((l == 2 ? tx_ready : up_ready[l]) !== 1'b1) begin
            @(negedge clk);
            #1;
        end
        @(posedge clk);
        if (l == 2) tx_valid <= 1'b0;
        else up_valid[l] <= 1'b0;
        exp_q[l == 2 ? (d > 4'h1 ? 0 : 1) : (d == 4'h1 ? 2 : l)].push_back(w);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Each word leaving the block meets the oldest note for its port
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++)
            if (!rst && dn_valid[i] === 1'b1 && dn_ready[i] === 1'b1)
                `CHK(dn_word[i], exp_q[i].pop_front())
        if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1)
            `CHK({4'h1, rx_src, rx_sop, rx_eop, rx_data}, exp_q[2].pop_front())
    end
    // Cuts a hang short well past the expected run length
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
    initial begin
        void'($urandom(12133));
        repeat (3) @(negedge clk);
        rst = 0;
        @(posedge clk);
        #1 `CHK({output_rst_n, rx_valid, dn_valid}, 4'h0)
        $display("test reset done");
        // Default pattern: upstream takes the first contest, local the next
        fork
            begin push(0, 4'h5); push(0, 4'h6); end
            push(2, 4'h7);
            begin
                @(negedge clk);
                #1 `CHK({tx_ready, up_ready[0]}, 2'b01)
                @(negedge clk);
                #1 `CHK({tx_ready, up_ready[0]}, 2'b10)
            end
        join
        $display("test arbitration done");
        // Random destinations on all inputs while every sink stalls
        @(negedge clk);
        stall = 1;
        repeat (30) fork
            push(2, 4'($urandom_range(10, 1)));
            push(0, 4'($urandom_range(10, 1)));
            push(1, 4'($urandom_range(10, 1)));
        join
        repeat (80) @(posedge clk);
        `CHK(exp_q[0].size() + exp_q[1].size() + exp_q[2].size(), 0)
        $display("test traffic done");
        print_verdict();
    end
endmodule
`default_nettype wire
